/* File: rtl/sld_top.sv */
// Purpose: Segment LCD driver with Wishbone register slave and scan timing
// Assumes: One clock; oscillator ticks arrive asynchronously and are synchronised
// Notes: Analog bias, ladders and pump are driven only through control outputs
`timescale 1ns/1ns
module sld_top
  import sld_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Clock sources and system state
  input wire logic secondary_crystal_osc_i,
  input wire logic low_freq_internal_osc_i,
  input wire logic cpu_sleep_i,
  // Panel drive
  output logic [7:0] backplane_line_o,
  output logic [45:0] frontplane_line_o,
  output logic [45:0] seg_pin_owner_o,
  output logic drive_polarity_o,
  output logic [1:0] bias_sel_o,
  output logic waveform_type_b_o,
  // Analog control
  output logic module_active_flag_o,
  output logic bias_ref_en_o,
  output logic ladder_high_power_o,
  output logic [7:0] voltage_control_1_o,
  output logic [7:0] voltage_control_2_o,
  output logic [7:0] contrast_control_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [5:0] pix_index(input logic [2:0] backplane_line, input int frontplane_line);
    pix_index = 6'((int'(backplane_line) * SLD_NUM_SEG_REGS) + (frontplane_line / 8));
  endfunction

  function automatic logic [7:0] last_mask(input logic is_last, input logic [7:0] val);
    last_mask = is_last ? (val & SLD_LAST_MASK) : val;
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] control_q;
  logic [7:0] phase_prescale_reg_q;
  logic [7:0] vcon1_q;
  logic [7:0] vcon2_q;
  logic [7:0] ladder_power_control_q;
  logic [7:0] contrast_q;
  logic [7:0] seg_en_q [SLD_NUM_SEG_REGS];
  logic [7:0] pix_q [SLD_NUM_PIX_REGS];

  logic req;
  logic wr_en;
  logic [9:0] word;
  logic [9:0] seg_off;
  logic [9:0] pix_off;
  logic seg_hit;
  logic pix_hit;
  logic [7:0] wdat;
  logic [7:0] rdat;

  logic [2:0] com_sel;
  logic [2:0] com_last;
  logic running;
  logic active_q;
  logic [1:0] bias_eff;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = req && wb_we_i && wb_sel_i[0];
  assign word = wb_adr_i[11:2];
  assign seg_off = word - SLD_A_SEG_BASE;
  assign pix_off = word - SLD_A_PIX_BASE;
  assign seg_hit = (word >= SLD_A_SEG_BASE) && (seg_off < 10'(SLD_NUM_SEG_REGS));
  assign pix_hit = (word >= SLD_A_PIX_BASE) && (pix_off < 10'(SLD_NUM_PIX_REGS));
  assign wdat = wb_dat_i[7:0];
  assign com_sel = control_q[SLD_CTL_COM_HI:0];
  assign com_last = com_sel;

  // ----------------------------------------------------------------
  // Wishbone answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  always_comb
  begin
    rdat = 8'h00;
    if (seg_hit)
      rdat = seg_en_q[seg_off[2:0]];
    else if (pix_hit)
      rdat = pix_q[pix_off[5:0]];
    else
    begin
      case (word)
        SLD_A_CONTROL: rdat = control_q;
        SLD_A_PHASE: rdat = phase_prescale_reg_q;
        SLD_A_VCON1: rdat = vcon1_q;
        SLD_A_VCON2: rdat = vcon2_q;
        SLD_A_LADDER: rdat = ladder_power_control_q;
        SLD_A_CONTRAST: rdat = contrast_q;
        SLD_A_STATUS: rdat = {7'h00, active_q};
        default: rdat = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (req)
      wb_dat_o <= {24'h000000, rdat};
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      control_q <= SLD_REG_RESET;
      phase_prescale_reg_q <= SLD_REG_RESET;
      vcon1_q <= SLD_REG_RESET;
      vcon2_q <= SLD_REG_RESET;
      ladder_power_control_q <= SLD_REG_RESET;
      contrast_q <= SLD_REG_RESET;
    end
    else if (wr_en)
    begin
      case (word)
        SLD_A_CONTROL: control_q <= wdat;
        SLD_A_PHASE: phase_prescale_reg_q <= wdat;
        SLD_A_VCON1: vcon1_q <= wdat;
        SLD_A_VCON2: vcon2_q <= wdat;
        SLD_A_LADDER: ladder_power_control_q <= wdat;
        SLD_A_CONTRAST: contrast_q <= wdat;
        default: control_q <= control_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Segment enables and pixel memory
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < SLD_NUM_SEG_REGS; i++)
        seg_en_q[i] <= SLD_REG_RESET;
    end
    else if (wr_en && seg_hit)
      seg_en_q[seg_off[2:0]] <= last_mask(seg_off[2:0] == 3'h5, wdat);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < SLD_NUM_PIX_REGS; i++)
        pix_q[i] <= SLD_REG_RESET;
    end
    else if (wr_en && pix_hit)
      pix_q[pix_off[5:0]] <= last_mask((pix_off % 10'h006) == 10'h005, wdat);
  end

  // ----------------------------------------------------------------
  // Clock source synchronisers and selection
  // ----------------------------------------------------------------
  logic [1:0] xtal_sync_q;
  logic [1:0] intosc_sync_q;
  logic src_prev_q;
  logic src_level;
  logic src_edge;
  sld_src_t src_sel;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      xtal_sync_q <= 2'h0;
      intosc_sync_q <= 2'h0;
    end
    else
    begin
      xtal_sync_q <= {xtal_sync_q[0], secondary_crystal_osc_i};
      intosc_sync_q <= {intosc_sync_q[0], low_freq_internal_osc_i};
    end
  end

  assign src_sel = control_q[SLD_CTL_CLKSEL] ? SLD_SRC_INTERNAL : SLD_SRC_CRYSTAL;

  always_comb
  begin
    case (src_sel)
      SLD_SRC_CRYSTAL: src_level = xtal_sync_q[1];
      SLD_SRC_INTERNAL: src_level = intosc_sync_q[1];
      default: src_level = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      src_prev_q <= 1'b0;
    else
      src_prev_q <= src_level;
  end

  assign src_edge = src_level && !src_prev_q;

  // ----------------------------------------------------------------
  // Run state and prescaler
  // ----------------------------------------------------------------
  assign running = control_q[SLD_CTL_ON] && !(control_q[SLD_CTL_SLEEP] && cpu_sleep_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      active_q <= 1'b0;
    else
      active_q <= running;
  end

  logic [3:0] presc_q;
  logic count_tick;

  assign count_tick = active_q && src_edge &&
    (presc_q == phase_prescale_reg_q[SLD_PS_RATIO_HI:0]);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !active_q)
      presc_q <= 4'h0;
    else if (src_edge)
      presc_q <= count_tick ? 4'h0 : presc_q + 4'h1;
  end

  // ----------------------------------------------------------------
  // Segment-time counter and common scan
  // ----------------------------------------------------------------
  logic [4:0] count_q;
  logic [2:0] com_q;
  logic half_q;
  logic pol_q;
  logic seg_end;
  logic type_b;

  assign type_b = phase_prescale_reg_q[SLD_PS_TYPEB];
  assign seg_end = count_tick && (count_q == SLD_LAST_COUNT);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !active_q)
      count_q <= 5'h00;
    else if (count_tick)
      count_q <= count_q + 5'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !active_q)
    begin
      com_q <= 3'h0;
      half_q <= 1'b0;
      pol_q <= 1'b0;
    end
    else if (seg_end)
    begin
      if (!type_b)
      begin
        half_q <= !half_q;
        pol_q <= !half_q;
        if (half_q)
          com_q <= (com_q >= com_last) ? 3'h0 : com_q + 3'h1;
      end
      else
      begin
        com_q <= (com_q >= com_last) ? 3'h0 : com_q + 3'h1;
        if (com_q >= com_last)
          pol_q <= !pol_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bias selection
  // ----------------------------------------------------------------
  always_comb
  begin
    bias_eff = SLD_BIAS_STATIC;
    if (com_sel == 3'h1 && control_q[SLD_CTL_BIAS_HI:SLD_CTL_BIAS_LO] == SLD_BIAS_HALF)
      bias_eff = SLD_BIAS_HALF;
    else if (com_sel >= 3'h2 &&
             control_q[SLD_CTL_BIAS_HI:SLD_CTL_BIAS_LO] == SLD_BIAS_THIRD)
      bias_eff = SLD_BIAS_THIRD;
  end

  // ----------------------------------------------------------------
  // Panel outputs
  // ----------------------------------------------------------------
  logic [45:0] seg_own;
  logic [45:0] seg_dark;

  always_comb
  begin
    for (int s = 0; s < SLD_NUM_SEGS; s++)
    begin
      seg_own[s] = seg_en_q[s / 8][s % 8];
      seg_dark[s] = pix_q[pix_index(com_q, s)][s % 8];
    end
    if (com_sel == 3'h7 || com_q == 3'h7)
      seg_own[SLD_SHARED_SEG] = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      backplane_line_o <= 8'h00;
      frontplane_line_o <= 46'h0;
      seg_pin_owner_o <= 46'h0;
      drive_polarity_o <= 1'b0;
    end
    else
    begin
      seg_pin_owner_o <= seg_own;
      drive_polarity_o <= active_q && pol_q;
      backplane_line_o <= active_q ? (8'h01 << com_q) : 8'h00;
      frontplane_line_o <= active_q ? (seg_dark & seg_own) : 46'h0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bias_sel_o <= SLD_BIAS_STATIC;
      waveform_type_b_o <= 1'b0;
      module_active_flag_o <= 1'b0;
      bias_ref_en_o <= 1'b0;
      ladder_high_power_o <= 1'b0;
      voltage_control_1_o <= SLD_REG_RESET;
      voltage_control_2_o <= SLD_REG_RESET;
      contrast_control_o <= SLD_REG_RESET;
    end
    else
    begin
      bias_sel_o <= bias_eff;
      waveform_type_b_o <= type_b;
      module_active_flag_o <= active_q;
      bias_ref_en_o <= active_q && ladder_power_control_q[SLD_RL_REF_EN];
      ladder_high_power_o <= active_q &&
        (count_q < {2'h0, ladder_power_control_q[SLD_RL_WIN_HI:0]});
      voltage_control_1_o <= vcon1_q;
      voltage_control_2_o <= vcon2_q;
      contrast_control_o <= contrast_q;
    end
  end

endmodule // sld_top

/* File: common/sld_pkg.sv */
// Purpose: Constants for the segment LCD driver block
// Assumes: Wishbone word addressing, 32-bit data, 8-bit registers in low bits
// Notes: Register map, field positions, reset values and scan constants
package sld_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int SLD_NUM_COMMONS = 8;
  localparam int SLD_NUM_SEGS = 46;
  localparam int SLD_NUM_SEG_REGS = 6;
  localparam int SLD_NUM_PIX_REGS = 48;
  localparam int SLD_SEG_COUNTS = 32;
  localparam logic [4:0] SLD_LAST_COUNT = 5'h1F;
  localparam int SLD_SHARED_SEG = 45;

  // ----------------------------------------------------------------
  // Word addresses (byte address = 4 * word)
  // ----------------------------------------------------------------
  localparam logic [9:0] SLD_A_CONTROL = 10'h000;
  localparam logic [9:0] SLD_A_PHASE = 10'h001;
  localparam logic [9:0] SLD_A_VCON1 = 10'h002;
  localparam logic [9:0] SLD_A_VCON2 = 10'h003;
  localparam logic [9:0] SLD_A_LADDER = 10'h004;
  localparam logic [9:0] SLD_A_CONTRAST = 10'h005;
  localparam logic [9:0] SLD_A_STATUS = 10'h006;
  localparam logic [9:0] SLD_A_SEG_BASE = 10'h010;
  localparam logic [9:0] SLD_A_PIX_BASE = 10'h040;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int SLD_CTL_ON = 7;
  localparam int SLD_CTL_SLEEP = 6;
  localparam int SLD_CTL_CLKSEL = 5;
  localparam int SLD_CTL_BIAS_HI = 4;
  localparam int SLD_CTL_BIAS_LO = 3;
  localparam int SLD_CTL_COM_HI = 2;

  // Phase register fields
  localparam int SLD_PS_TYPEB = 7;
  localparam int SLD_PS_RATIO_HI = 3;

  // Ladder register fields
  localparam int SLD_RL_REF_EN = 7;
  localparam int SLD_RL_WIN_HI = 2;

  // Unimplemented top bits of the last register of each group
  localparam logic [7:0] SLD_LAST_MASK = 8'h3F;
  localparam logic [7:0] SLD_REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Bias encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SLD_BIAS_STATIC = 2'h0;
  localparam logic [1:0] SLD_BIAS_HALF = 2'h1;
  localparam logic [1:0] SLD_BIAS_THIRD = 2'h2;

  typedef enum logic [1:0] {SLD_SRC_CRYSTAL, SLD_SRC_INTERNAL} sld_src_t;

endpackage

/* File: testbench/sld_top_sva.sv */
// Purpose: Port checker for the segment LCD driver
// Assumes: Single clock, synchronous reset
// Notes: Bound to sld_top below
`timescale 1ns/1ns
module sld_top_sva
  import sld_pkg::*;
(
  // Clock and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Panel and analog
  input wire logic [7:0] backplane_line_o,
  input wire logic [45:0] frontplane_line_o,
  input wire logic [45:0] seg_pin_owner_o,
  input wire logic [1:0] bias_sel_o,
  input wire logic module_active_flag_o,
  input wire logic bias_ref_en_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_ack_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("no ack");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_dat_hi;
    wb_dat_o[31:8] == 24'h0;
  endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper data set");
  property p_onehot;
    $onehot0(backplane_line_o);
  endproperty
  a_onehot: assert property (p_onehot) else $error("two commons");
  property p_owned;
    (frontplane_line_o & ~seg_pin_owner_o) == 46'h0;
  endproperty
  a_owned: assert property (p_owned) else $error("unowned pin");
  property p_ref;
    bias_ref_en_o |-> module_active_flag_o;
  endproperty
  a_ref: assert property (p_ref) else $error("ref on idle");
  property p_shared;
    backplane_line_o[7] |-> !seg_pin_owner_o[45];
  endproperty
  a_shared: assert property (p_shared) else $error("shared pin");
  property p_bias;
    bias_sel_o != 2'h3;
  endproperty
  a_bias: assert property (p_bias) else $error("bad bias");
  property p_idle;
    !module_active_flag_o && !$past(module_active_flag_o) |-> backplane_line_o == 8'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("idle drive");

  c_ack: cover property (wb_ack_o);
  c_com7: cover property (backplane_line_o[7]);
  c_half: cover property (bias_sel_o == SLD_BIAS_HALF);
endmodule // sld_top_sva

bind sld_top sld_top_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .backplane_line_o, .frontplane_line_o, .seg_pin_owner_o, .bias_sel_o,
  .module_active_flag_o, .bias_ref_en_o);

/* File: testbench/sld_panel_model.sv */
// Purpose: Passive panel glass model
// Assumes: One-hot common drive
// Notes: Records pixels seen per common
`timescale 1ns/1ns
module sld_panel_model
  import sld_pkg::*;
(
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic [7:0] bp_i,
  input wire logic [45:0] fp_i,
  input wire logic hp_i,
  output logic [7:0] seen_o,
  output logic hp_o,
  output logic [7:0][45:0] px_o
);
  always_ff @(posedge clk_i)
  begin
    if (clr_i)
    begin
      seen_o <= 8'h00;
      hp_o <= 1'b0;
    end
    else
    begin
      hp_o <= hp_o | hp_i;
      for (int i = 0; i < SLD_NUM_COMMONS; i++)
        if (bp_i[i])
        begin
          seen_o[i] <= 1'b1;
          px_o[i] <= fp_i;
        end
    end
  end
endmodule // sld_panel_model

/* File: testbench/sld_top_tb.sv */
// Purpose: Self-checking bench for the segment LCD driver
// Assumes: Oscillator rising edge every 8 cycles
// Notes: Panel model captures scanned pixels
`timescale 1ns/1ns
module sld_top_tb
  import sld_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic osc = 1'b0, cpu_sleep_i = 1'b0, clr = 1'b0;
  logic [1:0] dv = 2'h0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, drive_polarity_o, waveform_type_b_o, module_active_flag_o, bias_ref_en_o;
  logic ladder_high_power_o, hp;
  logic [7:0] backplane_line_o, voltage_control_1_o, voltage_control_2_o, contrast_control_o;
  logic [7:0] seen;
  logic [45:0] frontplane_line_o, seg_pin_owner_o;
  logic [7:0][45:0] px;
  logic [1:0] bias_sel_o;
  int failures = 0, n_checks = 0, n;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    dv <= dv + 2'h1;
    if (dv == 2'h3)
      osc <= ~osc;
  end

  sld_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .secondary_crystal_osc_i(~osc),
    .low_freq_internal_osc_i(osc), .cpu_sleep_i, .backplane_line_o, .frontplane_line_o,
    .seg_pin_owner_o, .drive_polarity_o, .bias_sel_o, .waveform_type_b_o,
    .module_active_flag_o, .bias_ref_en_o, .ladder_high_power_o, .voltage_control_1_o,
    .voltage_control_2_o, .contrast_control_o);
  sld_panel_model PANEL (.clk_i, .clr_i(clr), .bp_i(backplane_line_o),
    .fp_i(frontplane_line_o), .hp_i(ladder_high_power_o), .seen_o(seen), .hp_o(hp),
    .px_o(px));

  task automatic chk(input logic [45:0] g, input logic [45:0] e, input string m);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {a, 2'h0};
    wb_dat_i <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    chk(46'(k), 46'h2, "ack delay");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rc(input logic [9:0] a, input logic [7:0] e, input string m);
    wb(1'b0, a, 8'h00);
    chk(46'(rd), 46'(e), m);
  endtask

  task automatic scan_wait(input logic [7:0] e);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    for (n = 0; n < 12000 && seen !== e; n++)
      @(posedge clk_i);
    repeat (600) @(posedge clk_i);
    chk(46'(seen), 46'(e), "commons");
  endtask

  task automatic hold_len(input int e, input logic two, input string m);
    int c;
    logic [1:0] pv;
    c = 0;
    pv = 2'h0;
    while (backplane_line_o[0] !== 1'b1)
      @(posedge clk_i);
    while (backplane_line_o[0] === 1'b1)
      @(posedge clk_i);
    while (backplane_line_o[0] !== 1'b1)
      @(posedge clk_i);
    while (backplane_line_o[0] === 1'b1)
    begin
      pv[drive_polarity_o] = 1'b1;
      @(posedge clk_i);
      c++;
    end
    chk(46'(c), 46'(e), m);
    if (two)
      chk(46'(pv), 46'h3, "polarity");
  endtask

  task automatic t_regs;
    for (int i = 0; i < 6; i++)
    begin
      wb(1'b1, SLD_A_SEG_BASE + 10'(i), 8'hFF);
      rc(SLD_A_SEG_BASE + 10'(i), (i == 5) ? 8'h3F : 8'hFF, "seg en");
    end
    for (int i = 0; i < 48; i++)
    begin
      wb(1'b1, SLD_A_PIX_BASE + 10'(i), 8'hFF);
      rc(SLD_A_PIX_BASE + 10'(i), (i % 6 == 5) ? 8'h3F : 8'hFF, "pixel");
    end
    wb(1'b1, 10'h3FF, 8'h77);
    rc(10'h3FF, 8'h00, "unmapped");
    wb(1'b1, SLD_A_PHASE, 8'h80);
    wb(1'b1, SLD_A_VCON1, 8'h5A);
    rc(SLD_A_VCON1, 8'h5A, "vcon1");
    chk(46'(waveform_type_b_o), 46'h1, "type b");
    chk(46'(voltage_control_1_o), 46'h5A, "vcon1 out");
    wb(1'b1, SLD_A_VCON2, 8'hC3);
    wb(1'b1, SLD_A_CONTRAST, 8'h24);
    chk(46'({voltage_control_2_o, contrast_control_o}), 46'hC324, "vcon2 cst");
    $display("t_regs done");
  endtask

  task automatic t_scan;
    wb(1'b1, SLD_A_PHASE, 8'h00);
    wb(1'b1, SLD_A_PIX_BASE, 8'hA5);
    wb(1'b1, SLD_A_PIX_BASE + 10'h6, 8'h3C);
    wb(1'b1, SLD_A_SEG_BASE + 10'h1, 8'h00);
    wb(1'b1, SLD_A_LADDER, 8'h83);
    cpu_sleep_i <= 1'b1;
    wb(1'b1, SLD_A_CONTROL, 8'hA9);
    scan_wait(8'h03);
    chk(46'(bias_ref_en_o), 46'h1, "ref on");
    chk(46'(bias_sel_o), 46'(SLD_BIAS_HALF), "half");
    chk(46'(px[0][15:0]), 46'hA5, "com0");
    chk(46'(px[1][7:0]), 46'h3C, "com1");
    chk(46'(hp), 46'h1, "ladder");
    rc(SLD_A_STATUS, 8'h01, "status");
    hold_len(2 * SLD_SEG_COUNTS * 8, 1'b1, "com time A");
    wb(1'b1, SLD_A_CONTROL, 8'h00);
    repeat (4) @(posedge clk_i);
    chk(46'({module_active_flag_o, bias_ref_en_o, backplane_line_o}), 46'h0, "off");
    wb(1'b1, SLD_A_CONTROL, 8'hE9);
    repeat (4) @(posedge clk_i);
    chk(46'(module_active_flag_o), 46'h0, "sleep halt");
    cpu_sleep_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(46'(module_active_flag_o), 46'h1, "wake");
    wb(1'b1, SLD_A_CONTROL, 8'h00);
    repeat (4) @(posedge clk_i);
    $display("t_scan done");
  endtask

  task automatic t_eight;
    wb(1'b1, SLD_A_PHASE, 8'h81);
    wb(1'b1, SLD_A_CONTROL, 8'h97);
    repeat (4) @(posedge clk_i);
    chk(46'(seg_pin_owner_o[45:44]), 46'h1, "shared pin");
    chk(46'(bias_sel_o), 46'(SLD_BIAS_THIRD), "third");
    scan_wait(8'hFF);
    hold_len(SLD_SEG_COUNTS * 2 * 8, 1'b0, "com time B");
    wb(1'b1, SLD_A_CONTROL, 8'h8F);
    repeat (4) @(posedge clk_i);
    chk(46'(bias_sel_o), 46'(SLD_BIAS_STATIC), "fallback");
    wb(1'b1, SLD_A_CONTROL, 8'h00);
    $display("t_eight done");
  endtask

  task final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_scan();
    t_eight();
    final_report();
  end

  initial
  begin
    #600000;
    failures++;
    final_report();
  end
endmodule // sld_top_tb
